// [design/flash_seq_pkg.sv]
package flash_seq_pkg;
    localparam int ADDR_W     = 16;
    localparam int PAGE_W     = 7;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_W     = 15;
    localparam int SECTOR_BIT = 15;
    // opcode key is {op[7:4], op[2:0]}; op[3] is don't care
    localparam logic [6:0] KEY_WEN    = 7'h06;
    localparam logic [6:0] KEY_WDIS   = 7'h04;
    localparam logic [6:0] KEY_SRD    = 7'h05;
    localparam logic [6:0] KEY_SWR    = 7'h01;
    localparam logic [6:0] KEY_READ   = 7'h03;
    localparam logic [6:0] KEY_PROG   = 7'h02;
    localparam logic [6:0] KEY_SERASE = 7'h2a;
    localparam logic [6:0] KEY_CERASE = 7'h32;
    localparam int STAT_HW_PROT = 7;
    localparam int STAT_BP   = 2;
    localparam int STAT_WEL  = 1;
    localparam logic [7:0] STAT_BUSY_VAL = 8'hff;
    localparam logic [7:0] ERASED_VAL    = 8'hff;
    localparam logic       BP_RESET      = 1'b0;
    localparam logic       HW_PROT_RESET = 1'b0;
    localparam logic [1:0] ADDR_LAST     = 2'h2;
    localparam logic [14:0] SECTOR_LAST  = 15'h7fff;
    // timing
    localparam longint CLK_HZ        = 50_000_000;
    localparam longint CHIP_ERASE_S  = 2;
    localparam longint SECT_ERASE_MS = 500;
    localparam longint PROG_TIME_US  = 100;
    localparam int CHIP_CYC = int'(CHIP_ERASE_S * CLK_HZ);
    localparam int SECT_CYC = int'(SECT_ERASE_MS * CLK_HZ / 1000);
    localparam int PROG_CYC = int'(PROG_TIME_US * CLK_HZ / 1000000);
endpackage

// [design/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync #(
    parameter int N = 4
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset_n,
    input  wire logic         i_ce,
    input  wire logic [N-1:0] i_d,
    output logic      [N-1:0] o_q
);
    logic [N-1:0] ff1;
    logic [N-1:0] ff2;
    logic [N-1:0] ff3;

    for (genvar g = 0; g < N; g++)
    begin : g_bit
        always_ff @(posedge i_clk or negedge i_reset_n)
        begin
            if (!i_reset_n)
            begin
                ff1[g] <= 1'b1;
                ff2[g] <= 1'b1;
                ff3[g] <= 1'b1;
                o_q[g] <= 1'b1;
            end
            else if (i_ce)
            begin
                ff1[g] <= i_d[g];
                ff2[g] <= ff1[g];
                ff3[g] <= ff2[g];
                // change only counts once two stages agree
                if (ff2[g] == ff3[g])
                    o_q[g] <= ff3[g];
            end
        end
    end
endmodule // pin_sync

// [design/word_fifo.sv]
`timescale 1ns/1ps
module word_fifo #(
    parameter int W     = 15,
    parameter int DEPTH = 32
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset_n,
    input  wire logic         i_ce,
    input  wire logic         i_valid,
    output logic              o_ready,
    input  wire logic [W-1:0] i_data,
    output logic              o_valid,
    input  wire logic         i_ready,
    output logic      [W-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] store [0:DEPTH-1];
    logic [AW:0]  wr_ptr;
    logic [AW:0]  rd_ptr;
    logic         push;
    logic         pop;

    assign o_valid = wr_ptr != rd_ptr;
    assign o_ready = (wr_ptr[AW] == rd_ptr[AW])
                   || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
    assign o_data  = store[rd_ptr[AW-1:0]];
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else if (i_ce)
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_ce && push)
            store[wr_ptr[AW-1:0]] <= i_data;
    end
endmodule // word_fifo

// [design/spi_flash_array_sequencer.sv]
// Contract
// - hardware protection blocks clearing the protect-enable bit
// - locked blocks never written; writes need enable latch and protection off
// - read: opcode, three address bytes, then data MSB first
// - serial input ignored after read address received
// - read address advances each byte while chip select low
// - read address wraps from top of array to zero
// - program starts on chip-select rise only at a byte boundary
// - while busy only status read is accepted
// - busy flag reads one during cycle, zero after
// - program writes 1 to 128 bytes of one page
// - program address wraps within page; untouched bytes kept
// - over 128 bytes, later data replaces earlier in page
// - enable latch cleared at end of every write cycle
// - write without enable latch ignored until next frame
// - only lower sixteen address bits used
// - two 32K sectors split at 008000; any address selects sector
// - sector erase erases whole unlocked sector, self timed
// - chip erase erases both unlocked sectors, self timed
// - write-enable, write-disable, status read and write opcodes
// - read, program, sector erase and chip erase opcodes
// - all fields MSB first, frame starts at chip-select fall
// - block-protect bit set locks entire array
`timescale 1ns/1ps
module spi_flash_array_sequencer
    import flash_seq_pkg::*;
#(
    parameter int PROG_CYCLES   = PROG_CYC,
    parameter int SECTOR_CYCLES = SECT_CYC,
    parameter int CHIP_CYCLES   = CHIP_CYC
) (
    input  wire logic I_CLK,
    input  wire logic I_RESET_N,
    input  wire logic I_CE,
    input  wire logic I_CS_N,
    input  wire logic I_SCK,
    input  wire logic I_SI,
    input  wire logic I_WP_N,
    output logic      O_SO,
    output logic      O_SO_OE,
    output logic      O_BUSY,
    output logic      O_WEL,
    output logic      O_BP,
    output logic      O_HW_PROTECT_ENABLE_BIT
);
    typedef enum logic [2:0] {
        PH_CMD, PH_ADDR, PH_READ, PH_PROG, PH_STAT_RD, PH_STAT_WR,
        PH_DONE, PH_IGNORE
    } phase_t;
    typedef enum logic [1:0] {J_IDLE, J_PROG, J_ERASE, J_STAT} job_t;

    // ------------------------------
    // pin sampling
    // ------------------------------
    logic [3:0] pins;
    logic       cs_n;
    logic       sck;
    logic       si;
    logic       wp_n;
    logic       sck_q;
    logic       cs_q;

    pin_sync #(.N(4)) u_sync (
        .i_clk     (I_CLK),
        .i_reset_n (I_RESET_N),
        .i_ce      (I_CE),
        .i_d       ({I_CS_N, I_SCK, I_SI, I_WP_N}),
        .o_q       (pins)
    );
    assign {cs_n, sck, si, wp_n} = pins;

    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            sck_q <= 1'b0;
            cs_q  <= 1'b1;
        end
        else if (I_CE)
        begin
            sck_q <= sck;
            cs_q  <= cs_n;
        end
    end

    logic       sck_rise;
    logic       sck_fall;
    logic       cs_fall;
    logic       cs_rise;
    assign sck_rise = !cs_n && sck && !sck_q;
    assign sck_fall = !cs_n && !sck && sck_q;
    assign cs_fall  = !cs_n && cs_q;
    assign cs_rise  = cs_n && !cs_q;

    // ------------------------------
    // frame decoder
    // ------------------------------
    phase_t      ph;
    logic [2:0]  bitcnt;
    logic [7:0]  rx;
    logic [6:0]  key;
    logic [1:0]  ab_cnt;
    logic [15:0] addr;
    logic [7:0]  new_stat;
    logic        end_ok;
    logic        busy;
    logic        wel;
    logic        bp;
    logic        hw_protect_enable_bit;
    logic [7:0]  next_rx;
    logic [6:0]  next_key;
    logic [15:0] next_addr;
    logic        byte_done;

    assign next_rx   = {rx[6:0], si};
    assign next_key  = {next_rx[7:4], next_rx[2:0]};
    assign next_addr = {addr[7:0], next_rx};
    assign byte_done = sck_rise && (bitcnt == 3'h7);

    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            ph       <= PH_IGNORE;
            bitcnt   <= '0;
            rx       <= '0;
            key      <= '0;
            ab_cnt   <= '0;
            addr     <= '0;
            new_stat <= '0;
            end_ok   <= 1'b0;
        end
        else if (I_CE)
        begin
            if (cs_fall)
            begin
                ph     <= PH_CMD;
                bitcnt <= '0;
                end_ok <= 1'b0;
                ab_cnt <= '0;
            end
            else if (sck_rise)
            begin
                bitcnt <= bitcnt + 3'h1;
                rx     <= next_rx;
            end
            if (byte_done)
            begin
                case (ph)
                    PH_CMD:
                    begin
                        key <= next_key;
                        if (busy && next_key != KEY_SRD)
                            ph <= PH_IGNORE;
                        else
                        begin
                            case (next_key)
                                KEY_READ, KEY_PROG, KEY_SERASE:
                                    ph <= PH_ADDR;
                                KEY_SRD:
                                    ph <= PH_STAT_RD;
                                KEY_SWR:
                                    ph <= PH_STAT_WR;
                                KEY_WEN, KEY_WDIS, KEY_CERASE:
                                begin
                                    ph     <= PH_DONE;
                                    end_ok <= 1'b1;
                                end
                                default:
                                    ph <= PH_IGNORE;
                            endcase
                        end
                    end
                    PH_ADDR:
                    begin
                        addr   <= next_addr;
                        ab_cnt <= ab_cnt + 2'h1;
                        if (ab_cnt == ADDR_LAST)
                        begin
                            case (key)
                                KEY_READ:
                                    ph <= PH_READ;
                                KEY_PROG:
                                    ph <= PH_PROG;
                                default:
                                begin
                                    ph     <= PH_DONE;
                                    end_ok <= 1'b1;
                                end
                            endcase
                        end
                    end
                    PH_READ:
                        addr <= addr + 16'h1;
                    PH_PROG:
                    begin
                        addr[PAGE_W-1:0] <= addr[PAGE_W-1:0] + 7'h1;
                        end_ok <= 1'b1;
                    end
                    PH_STAT_WR:
                    begin
                        new_stat <= next_rx;
                        end_ok   <= 1'b1;
                        ph       <= PH_DONE;
                    end
                    default:
                        ph <= ph;
                endcase
            end
        end
    end

    // ------------------------------
    // page buffer
    // ------------------------------
    logic [7:0]   pbuf [0:127];
    logic [127:0] pvalid;
    logic [8:0]   prog_page;

    always_ff @(posedge I_CLK)
    begin
        if (I_CE && byte_done && ph == PH_PROG)
            pbuf[addr[PAGE_W-1:0]] <= next_rx;
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
            pvalid <= '0;
        else if (I_CE)
        begin
            // cleared only while idle, so a running job keeps its page
            if (cs_fall && !busy)
                pvalid <= '0;
            else if (byte_done && ph == PH_PROG)
                pvalid[addr[PAGE_W-1:0]] <= 1'b1;
        end
    end

    // ------------------------------
    // serial output
    // ------------------------------
    logic [7:0] mem [0:65535];
    logic [7:0] tx;
    logic [7:0] status;

    assign status = busy ? STAT_BUSY_VAL
                  : {hw_protect_enable_bit, 4'h0, bp, wel, 1'b0};

    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            tx      <= '0;
            O_SO    <= 1'b0;
            O_SO_OE <= 1'b0;
        end
        else if (I_CE)
        begin
            O_SO_OE <= !cs_n;
            if (cs_n)
                O_SO <= 1'b0;
            else if (sck_fall)
            begin
                O_SO <= tx[7];
                tx   <= {tx[6:0], 1'b0};
            end
            if (byte_done)
            begin
                if (ph == PH_ADDR && ab_cnt == ADDR_LAST && key == KEY_READ)
                    tx <= mem[next_addr];
                else if (ph == PH_READ)
                    tx <= mem[addr + 16'h1];
                else if ((ph == PH_CMD && next_key == KEY_SRD)
                         || ph == PH_STAT_RD)
                    tx <= status;
            end
        end
    end

    // ------------------------------
    // write cycle engine
    // ------------------------------
    job_t        job;
    logic [31:0] timer;
    logic [7:0]  pidx;
    logic [16:0] ea;
    logic [15:0] eend;
    logic        erase_run;
    logic        slot;
    logic        fifo_in_rdy;
    logic        fifo_out_vld;
    logic [14:0] fifo_out;
    logic        push_vld;
    logic        launch;
    logic        job_done;
    logic        hw_prot;

    assign hw_prot  = hw_protect_enable_bit && !wp_n;
    assign launch   = cs_rise && end_ok && bitcnt == 3'h0 && !busy;
    assign push_vld = job == J_PROG && !pidx[7] && pvalid[pidx[6:0]];
    assign job_done = busy && timer == 32'h0 && !erase_run
                   && pidx[7] && !fifo_out_vld;

    // drain takes every other cycle, so the buffer really backs up
    word_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk     (I_CLK),
        .i_reset_n (I_RESET_N),
        .i_ce      (I_CE),
        .i_valid   (push_vld),
        .o_ready   (fifo_in_rdy),
        .i_data    ({pidx[6:0], pbuf[pidx[6:0]]}),
        .o_valid   (fifo_out_vld),
        .i_ready   (slot),
        .o_data    (fifo_out)
    );

    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            job       <= J_IDLE;
            busy      <= 1'b0;
            timer     <= '0;
            pidx      <= 8'h80;
            ea        <= '0;
            eend      <= '0;
            erase_run <= 1'b0;
            slot      <= 1'b0;
            prog_page <= '0;
            wel       <= 1'b0;
            bp        <= BP_RESET;
            hw_protect_enable_bit <= HW_PROT_RESET;
        end
        else if (I_CE)
        begin
            slot <= !slot;
            if (launch)
            begin
                case (key)
                    KEY_WEN:
                        wel <= 1'b1;
                    KEY_WDIS:
                        wel <= 1'b0;
                    KEY_PROG:
                        if (wel && !bp)
                        begin
                            job       <= J_PROG;
                            busy      <= 1'b1;
                            timer     <= PROG_CYCLES;
                            pidx      <= 8'h00;
                            prog_page <= addr[15:7];
                        end
                    KEY_SERASE:
                        if (wel && !bp)
                        begin
                            job       <= J_ERASE;
                            busy      <= 1'b1;
                            timer     <= SECTOR_CYCLES;
                            ea        <= {1'b0, addr[SECTOR_BIT], 15'h0};
                            eend      <= {addr[SECTOR_BIT], SECTOR_LAST};
                            erase_run <= 1'b1;
                        end
                    KEY_CERASE:
                        if (wel && !bp)
                        begin
                            job       <= J_ERASE;
                            busy      <= 1'b1;
                            timer     <= CHIP_CYCLES;
                            ea        <= '0;
                            eend      <= 16'hffff;
                            erase_run <= 1'b1;
                        end
                    KEY_SWR:
                        if (wel && !hw_prot)
                        begin
                            job   <= J_STAT;
                            busy  <= 1'b1;
                            timer <= PROG_CYCLES;
                        end
                    default:
                        wel <= wel;
                endcase
            end
            else if (job_done)
            begin
                if (job == J_STAT)
                begin
                    bp   <= new_stat[STAT_BP];
                    hw_protect_enable_bit <= new_stat[STAT_HW_PROT];
                end
                job  <= J_IDLE;
                busy <= 1'b0;
                wel  <= 1'b0;
            end
            else if (busy && timer != 32'h0)
                timer <= timer - 32'h1;
            if (!pidx[7] && (!pvalid[pidx[6:0]] || fifo_in_rdy))
                pidx <= pidx + 8'h1;
            if (erase_run)
            begin
                ea <= ea + 17'h1;
                if (ea[15:0] == eend)
                    erase_run <= 1'b0;
            end
        end
    end

    // programming only takes cells from one to zero; no reset on the array
    always_ff @(posedge I_CLK)
    begin
        if (I_CE)
        begin
            if (erase_run)
                mem[ea[15:0]] <= ERASED_VAL;
            else if (fifo_out_vld && slot)
                mem[{prog_page, fifo_out[14:8]}] <=
                    mem[{prog_page, fifo_out[14:8]}] & fifo_out[7:0];
        end
    end

    assign O_BUSY = busy;
    assign O_WEL  = wel;
    assign O_BP   = bp;
    assign O_HW_PROTECT_ENABLE_BIT = hw_protect_enable_bit;
endmodule // spi_flash_array_sequencer

// [test/flash_seq_sva.sv]
`timescale 1ns/1ps
module flash_seq_sva #(
    parameter int PROG_CYCLES = 200
) (
    input  wire logic I_CLK,
    input  wire logic I_RESET_N,
    input  wire logic I_CS_N,
    input  wire logic I_WP_N,
    input  wire logic O_SO,
    input  wire logic O_SO_OE,
    input  wire logic O_BUSY,
    input  wire logic O_WEL,
    input  wire logic O_BP,
    input  wire logic O_HW_PROTECT_ENABLE_BIT
);
    logic [31:0] busy_len;
    logic [31:0] wp_low_len;
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RESET_N);
    // ------------------------------------------
    // busy run length
    // ------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RESET_N)
        if (!I_RESET_N)
            busy_len <= 32'h0;
        else if (O_BUSY)
            busy_len <= busy_len + 32'h1;
        else
            busy_len <= 32'h0;
    // pin low run; a status write launched with the pin already low
    // would end with this count past the cycle length plus sync delay
    always_ff @(posedge I_CLK or negedge I_RESET_N)
        if (!I_RESET_N)
            wp_low_len <= 32'h0;
        else if (!I_WP_N)
            wp_low_len <= wp_low_len + 32'h1;
        else
            wp_low_len <= 32'h0;
    // ------------------------------------------
    // properties
    // ------------------------------------------
    property p_oe_off;
        I_CS_N [*8] |-> !O_SO_OE && !O_SO;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("serial out driven while deselected");
    property p_oe_on;
        !I_CS_N [*8] |-> O_SO_OE;
    endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("serial out not enabled while selected");
    property p_busy_wel;
        $rose(O_BUSY) |-> $past(O_WEL);
    endproperty
    a_busy_wel: assert property (p_busy_wel)
        else $error("write cycle without enable latch");
    property p_busy_cs;
        $rose(O_BUSY) |-> I_CS_N;
    endproperty
    a_busy_cs: assert property (p_busy_cs)
        else $error("write cycle began inside a frame");
    property p_wel_end;
        $fell(O_BUSY) |-> ##[0:1] !O_WEL;
    endproperty
    a_wel_end: assert property (p_wel_end)
        else $error("enable latch kept after write cycle");
    property p_busy_len;
        $fell(O_BUSY) |-> busy_len >= 32'(PROG_CYCLES - 1);
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("write cycle shorter than its timer");
    property p_bits_cycle;
        $changed(O_BP) || $changed(O_HW_PROTECT_ENABLE_BIT)
            |-> $past(O_BUSY);
    endproperty
    a_bits_cycle: assert property (p_bits_cycle)
        else $error("protect bits changed outside a write cycle");
    property p_prot_hold;
        $fell(O_HW_PROTECT_ENABLE_BIT) |-> wp_low_len < 32'(PROG_CYCLES + 6);
    endproperty
    a_prot_hold: assert property (p_prot_hold)
        else $error("protect enable cleared with pin low");
    c_busy: cover property ($rose(O_BUSY));
    c_prot: cover property ($fell(O_HW_PROTECT_ENABLE_BIT));
    c_so: cover property ($rose(O_SO));
endmodule // flash_seq_sva
bind spi_flash_array_sequencer flash_seq_sva #(
    .PROG_CYCLES(PROG_CYCLES)
) flash_seq_sva_i (
    .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_CS_N(I_CS_N),
    .I_WP_N(I_WP_N), .O_SO(O_SO), .O_SO_OE(O_SO_OE), .O_BUSY(O_BUSY),
    .O_WEL(O_WEL), .O_BP(O_BP),
    .O_HW_PROTECT_ENABLE_BIT(O_HW_PROTECT_ENABLE_BIT)
);

// [test/spi_host.sv]
`timescale 1ns/1ps
module spi_host (
    input  wire logic i_clk,
    input  wire logic i_so,
    output logic      o_cs_n,
    output logic      o_sck,
    output logic      o_si
);
    logic [7:0] rx[$];
    logic [7:0] sh;
    initial
    begin
        o_cs_n = 1'h1;
        o_sck  = 1'h0;
        o_si   = 1'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // ------------------------------------------
    // frame; extra bits end it mid-byte
    // ------------------------------------------
    task automatic frame(input logic [7:0] tx[$], input int extra);
        logic [7:0] b;
        rx.delete();
        tick(1);
        o_cs_n = 1'h0;
        for (int i = 0; i < tx.size() * 8 + extra; i++)
        begin
            b = (i < tx.size() * 8) ? tx[i / 8] : 8'h00;
            o_si = b[7 - i % 8];
            tick(4);
            o_sck = 1'h1;
            tick(4);
            sh = {sh[6:0], i_so};
            if (i % 8 == 7)
                rx.push_back(sh);
            o_sck = 1'h0;
        end
        tick(2);
        o_cs_n = 1'h1;
        // released line shows the inverse, never a stale level
        o_si = ~o_si;
        tick(10);
    endtask
endmodule // spi_host

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
    import flash_seq_pkg::*;
    logic       I_CLK     = 1'h0;
    logic       I_RESET_N = 1'h0;
    logic       I_WP_N    = 1'h1;
    logic       I_CS_N, I_SCK, I_SI;
    logic       O_SO, O_SO_OE, O_BUSY, O_WEL, O_BP, O_HW_PROTECT_ENABLE_BIT;
    logic [7:0] r[$];
    int         n_errors     = 0;
    int         total_checks = 0;
    int         cycles       = 0;
    always #10 I_CLK = ~I_CLK;
    spi_flash_array_sequencer #(
        .PROG_CYCLES(200), .SECTOR_CYCLES(40000), .CHIP_CYCLES(65600)
    ) spi_flash_array_sequencer_i (
        .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_CE(1'h1),
        .I_CS_N(I_CS_N), .I_SCK(I_SCK), .I_SI(I_SI), .I_WP_N(I_WP_N),
        .O_SO(O_SO), .O_SO_OE(O_SO_OE), .O_BUSY(O_BUSY), .O_WEL(O_WEL),
        .O_BP(O_BP), .O_HW_PROTECT_ENABLE_BIT(O_HW_PROTECT_ENABLE_BIT)
    );
    spi_host spi_host_i (
        .i_clk(I_CLK), .i_so(O_SO), .o_cs_n(I_CS_N), .o_sck(I_SCK),
        .o_si(I_SI)
    );
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (n_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic xfer(input logic [7:0] q[$]);
        spi_host_i.frame(q, 0);
        r = spi_host_i.rx;
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            xfer('{8'h05, 8'h00});
            n++;
        end
        while (r[1][0] !== 1'h0 && n < 1000);
    endtask
    task automatic t_chip_erase();
        xfer('{8'h06});
        xfer('{8'h0d, 8'h00});
        check(r[1], 8'h02);
        xfer('{8'h6a});
        xfer('{8'h05, 8'h00});
        check(r[1], STAT_BUSY_VAL);
        xfer('{8'h04});
        check({7'h0, O_WEL}, 8'h01);
        wait_ready();
        check(r[1], 8'h00);
        xfer('{8'h03, 8'h00, 8'h9a, 8'hbc, 8'h00});
        check(r[4], ERASED_VAL);
    endtask
    task automatic t_program();
        xfer('{8'h06});
        xfer('{8'h02, 8'h5a, 8'h12, 8'h7e, 8'ha5, 8'h3c, 8'h0f});
        wait_ready();
        check(r[1], 8'h00);
        xfer('{8'h0b, 8'hc3, 8'h12, 8'h7e, 8'h00, 8'h00, 8'h00});
        check(r[4], 8'ha5);
        check(r[5], 8'h3c);
        check(r[6], ERASED_VAL);
        xfer('{8'h03, 8'h00, 8'h12, 8'h00, 8'h00, 8'h00});
        check(r[4], 8'h0f);
        check(r[5], ERASED_VAL);
    endtask
    task automatic t_overfill();
        logic [7:0] q[$];
        q = '{8'h02, 8'h00, 8'h20, 8'h10};
        for (int i = 0; i < 130; i++)
            q.push_back(8'(i) + 8'h40);
        xfer('{8'h06});
        xfer(q);
        wait_ready();
        xfer('{8'h03, 8'h00, 8'h20, 8'h10, 8'h00, 8'h00, 8'h00});
        check(r[4], 8'hc0);
        check(r[5], 8'hc1);
        check(r[6], 8'h42);
        xfer('{8'h03, 8'h00, 8'h20, 8'h00, 8'h00});
        check(r[4], 8'hb0);
    endtask
    task automatic t_refuse();
        xfer('{8'h02, 8'h00, 8'h30, 8'h00, 8'h00});
        xfer('{8'h05, 8'h00});
        check(r[1], 8'h00);
        xfer('{8'h52, 8'h00, 8'h30, 8'h00});
        xfer('{8'h05, 8'h00});
        check(r[1], 8'h00);
        xfer('{8'h06});
        spi_host_i.frame('{8'h02, 8'h00, 8'h30, 8'h00, 8'h00}, 4);
        xfer('{8'h05, 8'h00});
        check(r[1], 8'h02);
        xfer('{8'h0c});
        xfer('{8'h03, 8'h00, 8'h30, 8'h00, 8'h00});
        check(r[4], ERASED_VAL);
        xfer('{8'h05, 8'h00});
        check(r[1], 8'h00);
    endtask
    task automatic t_wrap_read();
        xfer('{8'h06});
        xfer('{8'h0a, 8'h00, 8'hff, 8'hff, 8'h11});
        wait_ready();
        xfer('{8'h03, 8'h00, 8'hff, 8'hff, 8'h06, 8'h06});
        check(r[4], 8'h11);
        check(r[5], ERASED_VAL);
        xfer('{8'h05, 8'h00});
        check(r[1], 8'h00);
    endtask
    task automatic t_protect();
        xfer('{8'h06});
        xfer('{8'h09, 8'h84});
        wait_ready();
        check({6'h0, O_HW_PROTECT_ENABLE_BIT, O_BP}, 8'h03);
        xfer('{8'h06});
        xfer('{8'h02, 8'h00, 8'h12, 8'h7e, 8'h00});
        xfer('{8'h05, 8'h00});
        check(r[1], 8'h86);
        xfer('{8'h5a, 8'h00, 8'h12, 8'h34});
        xfer('{8'h05, 8'h00});
        check(r[1], 8'h86);
        I_WP_N = 1'h0;
        xfer('{8'h01, 8'h00});
        xfer('{8'h05, 8'h00});
        check(r[1], 8'h86);
        I_WP_N = 1'h1;
        xfer('{8'h01, 8'h00});
        wait_ready();
        check(r[1], 8'h00);
        xfer('{8'h03, 8'h00, 8'h12, 8'h7e, 8'h00});
        check(r[4], 8'ha5);
    endtask
    initial
    begin
        repeat (20) @(posedge I_CLK);
        #1;
        I_RESET_N = 1'h1;
        repeat (8) @(posedge I_CLK);
        t_chip_erase();
        t_program();
        t_overfill();
        t_refuse();
        t_wrap_read();
        t_protect();
        stop_test();
    end
    always @(posedge I_CLK)
    begin
        cycles++;
        if (cycles == 98000)
        begin
            n_errors++;
            stop_test();
        end
    end
endmodule // tb
